// [rtl/pacm_ch1_engine.sv]
`timescale 1ns/100ps
module pacm_ch1_engine (
  input  wire logic                              clk_sys,
  input  wire logic                              reset,
  input  wire logic [pacm_pkg::COUNT_WIDTH-1:0]  counter_value,
  input  wire logic [pacm_pkg::COUNT_WIDTH-1:0]  compare_value,
  input  wire pacm_pkg::pacm_mode_t              mode,
  input  wire logic                              wide_pwm_select,
  input  wire logic                              center_align,
  input  wire logic                              comparator_enable,
  input  wire logic                              rising_capture_enable,
  input  wire logic                              falling_capture_enable,
  input  wire logic                              match_flag_enable,
  input  wire logic                              ch1_input,
  output logic                                   ch1_output,
  output logic [pacm_pkg::COUNT_WIDTH-1:0]       capture_value,
  output logic                                   flag_set
);
  import pacm_pkg::*;

  logic                   input_prev_reg;
  logic                   out_reg;
  logic                   out_next;
  logic [COUNT_WIDTH-1:0] cap_reg;
  logic [COUNT_WIDTH-2:0] fold_wide;
  logic [NARROW_WIDTH-2:0] fold_narrow;
  logic                   level_wide;
  logic                   level_narrow;
  logic                   pwm_level;
  logic                   full_match;
  logic                   low_match;
  logic                   rise_edge;
  logic                   fall_edge;
  logic                   capture_hit;
  logic                   match_hit;

  // ***********************************************
  // event detection
  // ***********************************************
  assign full_match  = comparator_enable && (counter_value == compare_value);
  assign low_match   = comparator_enable &&
                       (counter_value[NARROW_WIDTH-1:0] == compare_value[NARROW_WIDTH-1:0]);
  assign rise_edge   = ch1_input && !input_prev_reg;
  assign fall_edge   = !ch1_input && input_prev_reg;
  // both enables together capture on every transition
  assign capture_hit = (rise_edge && rising_capture_enable) ||
                       (fall_edge && falling_capture_enable);
  assign match_hit   = full_match && match_flag_enable;
  assign flag_set    = capture_hit || match_hit;

  // ***********************************************
  // pwm level, edge or center aligned
  // ***********************************************
  // center alignment folds the count into a triangle so the pulse is symmetric
  assign fold_wide    = counter_value[COUNT_WIDTH-1] ? ~counter_value[COUNT_WIDTH-2:0]
                                                     : counter_value[COUNT_WIDTH-2:0];
  assign fold_narrow  = counter_value[NARROW_WIDTH-1] ? ~counter_value[NARROW_WIDTH-2:0]
                                                      : counter_value[NARROW_WIDTH-2:0];
  assign level_wide   = center_align ? ({fold_wide, 1'b0} < compare_value)
                                     : (counter_value < compare_value);
  assign level_narrow = center_align ?
                        ({fold_narrow, 1'b0} < compare_value[COUNT_WIDTH-1:NARROW_WIDTH]) :
                        (counter_value[NARROW_WIDTH-1:0] < compare_value[COUNT_WIDTH-1:NARROW_WIDTH]);
  assign pwm_level    = comparator_enable &&
                        (wide_pwm_select ? level_wide : level_narrow);

  always_comb begin
    case (mode)
      PACM_PWM:    out_next = pwm_level;
      PACM_FREQ:   out_next = low_match ? !out_reg : out_reg;
      PACM_TOGGLE: out_next = full_match ? !out_reg : out_reg;
      default:     out_next = out_reg;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      input_prev_reg <= 1'b0;
      out_reg        <= 1'b0;
      cap_reg        <= '0;
    end else begin
      input_prev_reg <= ch1_input;
      out_reg        <= out_next;
      if (capture_hit) begin
        cap_reg <= counter_value;
      end
    end
  end

  assign ch1_output    = out_reg;
  assign capture_value = cap_reg;

  // ***********************************************
  // checks
  // ***********************************************
  capture_copy_a: assert property (@(posedge clk_sys) disable iff (reset)
    capture_hit |=> capture_value == $past(counter_value))
    else $error("capture value not taken from counter");

  toggle_invert_a: assert property (@(posedge clk_sys) disable iff (reset)
    (mode == PACM_TOGGLE && full_match) |=> ch1_output != $past(ch1_output))
    else $error("toggle mode did not invert output on match");

  both_edges_a: assert property (@(posedge clk_sys) disable iff (reset)
    (rising_capture_enable && falling_capture_enable && ch1_input != input_prev_reg) |-> flag_set)
    else $error("transition not captured with both edges enabled");

endmodule : pacm_ch1_engine

// [rtl/pacm_pkg.sv]
package pacm_pkg;

  // ***********************************************
  // register addresses and field positions
  // ***********************************************
  localparam logic [7:0] ALIGN_SEL_ADDR   = 8'h9e;
  localparam logic [7:0] CH1_MODE_ADDR    = 8'hdb;
  localparam logic [7:0] ALIGN_SEL_RESET  = 8'h00;
  localparam logic [7:0] CH1_MODE_RESET   = 8'h00;
  localparam int         ALIGN_BITS       = 3;
  localparam int         CH0_ALIGN_BIT    = 0;
  localparam int         CH1_ALIGN_BIT    = 1;
  localparam int         CH2_ALIGN_BIT    = 2;
  localparam int         WIDE_PWM_BIT     = 7;
  localparam int         CMP_EN_BIT       = 6;
  localparam int         RISE_CAP_BIT     = 5;
  localparam int         FALL_CAP_BIT     = 4;
  localparam int         MATCH_FLAG_BIT   = 3;
  localparam int         TOGGLE_BIT       = 2;
  localparam int         PWM_BIT          = 1;
  localparam int         FLAG_IRQ_BIT     = 0;
  localparam int         COUNT_WIDTH      = 16;
  localparam int         NARROW_WIDTH     = 8;

  // ***********************************************
  // channel operating modes
  // ***********************************************
  typedef enum logic [4:0] {
    PACM_IDLE    = 5'b00001,
    PACM_CAPTURE = 5'b00010,
    PACM_TOGGLE  = 5'b00100,
    PACM_PWM     = 5'b01000,
    PACM_FREQ    = 5'b10000
  } pacm_mode_t;

endpackage : pacm_pkg

// [rtl/pacm_top.sv]
// Notes on behaviour
// - alignment bit per channel, 0 edge, 1 center
// - alignment ignored outside pwm modes
// - bit 7 picks narrow or 16-bit pwm
// - bit 6 enables counter to compare matching
// - bit 5 captures on rising input edge
// - bit 4 captures on falling input edge
// - bit 3 sets channel flag on match
// - bit 2 toggles output on match
// - bit 1 drives pwm waveform on output
// - toggle plus pwm gives frequency output
// - bit 0 gates flag onto interrupt request
`timescale 1ns/100ps
module pacm_top (
  input  wire logic                              clk_sys,
  input  wire logic                              reset,
  input  wire logic [7:0]                        sfr_addr,
  input  wire logic                              sfr_wr_en,
  input  wire logic [7:0]                        sfr_wdata,
  input  wire logic                              sfr_rd_en,
  output logic [7:0]                             sfr_rdata,
  input  wire logic [pacm_pkg::COUNT_WIDTH-1:0]  counter_value,
  input  wire logic [pacm_pkg::COUNT_WIDTH-1:0]  ch1_compare_value,
  input  wire logic                              ch0_pwm_active,
  input  wire logic                              ch2_pwm_active,
  input  wire logic                              ch1_input,
  input  wire logic                              ch1_event_flag,
  output logic                                   ch1_flag_set,
  output logic                                   ch1_irq_request,
  output logic                                   ch1_output,
  output logic [pacm_pkg::COUNT_WIDTH-1:0]       ch1_capture_value,
  output logic [pacm_pkg::ALIGN_BITS-1:0]        center_align_active
);
  import pacm_pkg::*;

  // ***********************************************
  // register file
  // ***********************************************
  logic [ALIGN_BITS-1:0] align_reg;
  logic [ALIGN_BITS-1:0] align_next;
  logic [7:0]            mode_reg;
  logic [7:0]            mode_next;
  logic [7:0]            rdata_reg;
  logic [7:0]            rdata_next;
  logic                  hit_align;
  logic                  hit_mode;
  logic [7:0]            align_view;

  assign hit_align  = (sfr_addr == ALIGN_SEL_ADDR);
  assign hit_mode   = (sfr_addr == CH1_MODE_ADDR);
  // only the three live bits are stored, so bits 7:3 cannot read back nonzero
  assign align_view = {{(8 - ALIGN_BITS){1'b0}}, align_reg};
  assign align_next = (sfr_wr_en && hit_align) ? sfr_wdata[ALIGN_BITS-1:0] : align_reg;
  assign mode_next  = (sfr_wr_en && hit_mode) ? sfr_wdata : mode_reg;
  // unmapped addresses read as zero
  assign rdata_next = !sfr_rd_en ? rdata_reg :
                      hit_align  ? align_view :
                      hit_mode   ? mode_reg : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      align_reg <= ALIGN_SEL_RESET[ALIGN_BITS-1:0];
      mode_reg  <= CH1_MODE_RESET;
      rdata_reg <= 8'h00;
    end else begin
      align_reg <= align_next;
      mode_reg  <= mode_next;
      rdata_reg <= rdata_next;
    end
  end

  assign sfr_rdata = rdata_reg;

  // ***********************************************
  // channel 1 mode fields
  // ***********************************************
  logic       wide_pwm_select;
  logic       comparator_enable;
  logic       rising_capture_enable;
  logic       falling_capture_enable;
  logic       match_flag_enable;
  logic       toggle_enable;
  logic       pwm_enable;
  logic       flag_interrupt_enable;
  pacm_mode_t ch1_mode;

  assign wide_pwm_select        = mode_reg[WIDE_PWM_BIT];
  assign comparator_enable      = mode_reg[CMP_EN_BIT];
  assign rising_capture_enable  = mode_reg[RISE_CAP_BIT];
  assign falling_capture_enable = mode_reg[FALL_CAP_BIT];
  assign match_flag_enable      = mode_reg[MATCH_FLAG_BIT];
  assign toggle_enable          = mode_reg[TOGGLE_BIT];
  assign pwm_enable             = mode_reg[PWM_BIT];
  assign flag_interrupt_enable  = mode_reg[FLAG_IRQ_BIT];

  // frequency output takes priority over plain pwm and plain toggle
  always_comb begin
    if (toggle_enable && pwm_enable) begin
      ch1_mode = PACM_FREQ;
    end else if (pwm_enable) begin
      ch1_mode = PACM_PWM;
    end else if (toggle_enable) begin
      ch1_mode = PACM_TOGGLE;
    end else if (rising_capture_enable || falling_capture_enable) begin
      ch1_mode = PACM_CAPTURE;
    end else begin
      ch1_mode = PACM_IDLE;
    end
  end

  // ***********************************************
  // alignment per channel
  // ***********************************************
  logic [ALIGN_BITS-1:0] pwm_active;
  logic                  ch1_pwm_active;

  assign ch1_pwm_active = (ch1_mode == PACM_PWM);
  assign pwm_active     = {ch2_pwm_active, ch1_pwm_active, ch0_pwm_active};

  genvar gi;
  generate
    for (gi = 0; gi < ALIGN_BITS; gi = gi + 1) begin : g_align
      // alignment has no meaning outside pwm, so it is masked there
      assign center_align_active[gi] = align_reg[gi] && pwm_active[gi];
    end
  endgenerate

  // ***********************************************
  // channel 1 engine and interrupt request
  // ***********************************************
  pacm_ch1_engine u_engine (
    .clk_sys                (clk_sys),
    .reset                  (reset),
    .counter_value          (counter_value),
    .compare_value          (ch1_compare_value),
    .mode                   (ch1_mode),
    .wide_pwm_select        (wide_pwm_select),
    .center_align           (center_align_active[CH1_ALIGN_BIT]),
    .comparator_enable      (comparator_enable),
    .rising_capture_enable  (rising_capture_enable),
    .falling_capture_enable (falling_capture_enable),
    .match_flag_enable      (match_flag_enable),
    .ch1_input              (ch1_input),
    .ch1_output             (ch1_output),
    .capture_value          (ch1_capture_value),
    .flag_set               (ch1_flag_set)
  );

  // the flag itself lives in the counter mode register outside this block
  assign ch1_irq_request = ch1_event_flag && flag_interrupt_enable;

  // ***********************************************
  // checks
  // ***********************************************
  sequence align_write_s;
    sfr_wr_en && hit_align;
  endsequence

  sequence align_read_s;
    sfr_rd_en && hit_align && !sfr_wr_en;
  endsequence

  align_upper_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
    align_write_s ##1 align_read_s |=> sfr_rdata[7:ALIGN_BITS] == 5'h00 &&
      sfr_rdata[ALIGN_BITS-1:0] == $past(sfr_wdata[ALIGN_BITS-1:0], 2))
    else $error("alignment readback wrong");

  align_nonpwm_a: assert property (@(posedge clk_sys) disable iff (reset)
    !ch1_pwm_active |-> !center_align_active[CH1_ALIGN_BIT])
    else $error("alignment active outside pwm");

  align_follow_a: assert property (@(posedge clk_sys) disable iff (reset)
    align_write_s ##1 (ch0_pwm_active && !sfr_wr_en) |->
      center_align_active[CH0_ALIGN_BIT] == $past(sfr_wdata[CH0_ALIGN_BIT]))
    else $error("channel 0 alignment does not follow its bit");

  irq_mask_a: assert property (@(posedge clk_sys) disable iff (reset)
    ch1_irq_request == (ch1_event_flag && mode_reg[FLAG_IRQ_BIT]))
    else $error("interrupt request not gated by mask");

  match_flag_a: assert property (@(posedge clk_sys) disable iff (reset)
    (mode_reg[MATCH_FLAG_BIT] && mode_reg[CMP_EN_BIT] &&
     counter_value == ch1_compare_value) |-> ch1_flag_set)
    else $error("match did not set flag");

  no_cmp_no_match_a: assert property (@(posedge clk_sys) disable iff (reset)
    (!mode_reg[CMP_EN_BIT] && !mode_reg[RISE_CAP_BIT] && !mode_reg[FALL_CAP_BIT]) |-> !ch1_flag_set)
    else $error("flag set with comparator and capture off");

  freq_mode_a: assert property (@(posedge clk_sys) disable iff (reset)
    (mode_reg[TOGGLE_BIT] && mode_reg[PWM_BIT]) |-> ch1_mode == PACM_FREQ)
    else $error("toggle with pwm is not frequency output");

  pwm_wide_a: assert property (@(posedge clk_sys) disable iff (reset)
    (ch1_mode == PACM_PWM && mode_reg[WIDE_PWM_BIT] && mode_reg[CMP_EN_BIT] &&
     !center_align_active[CH1_ALIGN_BIT] && !sfr_wr_en) |=>
      ch1_output == ($past(counter_value) < $past(ch1_compare_value)))
    else $error("wide edge pwm level wrong");

  rise_capture_a: assert property (@(posedge clk_sys) disable iff (reset)
    (mode_reg[RISE_CAP_BIT] && ch1_input && !$past(ch1_input)) |-> ch1_flag_set ##1
      ch1_capture_value == $past(counter_value))
    else $error("rising edge not captured");

  fall_capture_a: assert property (@(posedge clk_sys) disable iff (reset)
    (mode_reg[FALL_CAP_BIT] && !ch1_input && $past(ch1_input)) |-> ch1_flag_set)
    else $error("falling edge not captured");

  // pwm level is gated by the comparator, so a pwm channel without it idles low
  pwm_needs_cmp_a: assert property (@(posedge clk_sys) disable iff (reset)
    (ch1_mode == PACM_PWM && !mode_reg[CMP_EN_BIT]) |=> !ch1_output)
    else $error("pwm output high with comparator off");

  // narrow pwm compares the low count byte against the high compare byte
  pwm_narrow_a: assert property (@(posedge clk_sys) disable iff (reset)
    (ch1_mode == PACM_PWM && !mode_reg[WIDE_PWM_BIT] && mode_reg[CMP_EN_BIT] &&
     !center_align_active[CH1_ALIGN_BIT]) |=>
      ch1_output == ($past(counter_value[NARROW_WIDTH-1:0]) <
                     $past(ch1_compare_value[COUNT_WIDTH-1:NARROW_WIDTH])))
    else $error("narrow edge pwm level wrong");

endmodule : pacm_top

// [verif/pacm_ext_model.sv]
`timescale 1ns/100ps
// ***********************************************
// outside circuitry: capture pin driver and flag
// ***********************************************
module pacm_ext_model (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic edge_req,
  input  wire logic flag_clear,
  input  wire logic flag_set,
  output logic      ch1_input,
  output logic      ch1_event_flag
);
  // the pin only moves on request, so every capture edge is one the bench planned
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ch1_input      <= 1'b0;
      ch1_event_flag <= 1'b0;
    end else begin
      if (edge_req) begin
        ch1_input <= ~ch1_input;
      end
      // a software clear wins over a set in the same cycle
      if (flag_clear) begin
        ch1_event_flag <= 1'b0;
      end else if (flag_set) begin
        ch1_event_flag <= 1'b1;
      end
    end
  end
endmodule : pacm_ext_model

// [verif/pwm_align_and_ch1_mode_ctrl_bench.sv]
`timescale 1ns/100ps
module pwm_align_and_ch1_mode_ctrl_bench;
  import pacm_pkg::*;
  logic        clk_sys, reset, sfr_wr_en, sfr_rd_en, ch1_input, ch1_event_flag;
  logic        ch0_pwm_active, ch2_pwm_active, edge_req, flag_clear;
  logic        ch1_flag_set, ch1_irq_request, ch1_output;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, rd, d, m;
  logic [15:0] counter_value, ch1_compare_value, ch1_capture_value, c, cv, cap;
  logic [2:0]  center_align_active;
  logic [31:0] seed, r;
  logic        exp_o, fs, flg;
  int          mismatches, checked;

  pacm_top u_pacm_top (.clk_sys(clk_sys), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
    .sfr_wdata(sfr_wdata), .sfr_rd_en(sfr_rd_en), .sfr_rdata(sfr_rdata), .counter_value(counter_value),
    .ch1_compare_value(ch1_compare_value), .ch0_pwm_active(ch0_pwm_active), .ch2_pwm_active(ch2_pwm_active),
    .ch1_input(ch1_input), .ch1_event_flag(ch1_event_flag), .ch1_flag_set(ch1_flag_set),
    .ch1_irq_request(ch1_irq_request), .ch1_output(ch1_output), .ch1_capture_value(ch1_capture_value),
    .center_align_active(center_align_active));
  pacm_ext_model u_pacm_ext_model (.clk_sys(clk_sys), .reset(reset), .edge_req(edge_req),
    .flag_clear(flag_clear), .flag_set(ch1_flag_set), .ch1_input(ch1_input), .ch1_event_flag(ch1_event_flag));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ***********************************************
  // helpers
  // ***********************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // ch1 counts as pwm with pwm set and toggle clear; the comparator only gates the level
  function automatic logic [2:0] exp_center(input logic [7:0] al, input logic [7:0] md, input logic p0,
                                            input logic p2);
    return al[2:0] & {p2, md[1] & ~md[2], p0};
  endfunction : exp_center

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    sfr_addr  <= a;
    sfr_wdata <= v;
    sfr_wr_en <= 1'b1;
    @(posedge clk_sys);
    sfr_wr_en <= 1'b0;
  endtask : sfr_write

  task automatic sfr_read(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    sfr_addr  <= a;
    sfr_rd_en <= 1'b1;
    @(posedge clk_sys);
    sfr_rd_en <= 1'b0;
    #1;
    v = sfr_rdata;
  endtask : sfr_read

  // write then read back on the very next edge, the tightest order the bus allows
  task automatic sfr_write_read(input logic [7:0] a, input logic [7:0] v, output logic [7:0] rv);
    @(posedge clk_sys);
    sfr_addr  <= a;
    sfr_wdata <= v;
    sfr_wr_en <= 1'b1;
    @(posedge clk_sys);
    sfr_wr_en <= 1'b0;
    sfr_rd_en <= 1'b1;
    @(posedge clk_sys);
    sfr_rd_en <= 1'b0;
    #1;
    rv = sfr_rdata;
  endtask : sfr_write_read

  // output is registered: it follows the counter seen at the next edge
  task automatic step(input logic [15:0] now, input logic [15:0] after, input logic e);
    @(posedge clk_sys);
    counter_value <= now;
    @(posedge clk_sys);
    counter_value <= after;
    #1;
    check(ch1_output, e);
  endtask : step

  task automatic complete_run();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    complete_run();
  end

  // ***********************************************
  // main sequence
  // ***********************************************
  initial begin
    seed = 32'h39;
    {reset, sfr_wr_en, sfr_rd_en, edge_req, flag_clear} = 5'h10;
    {ch0_pwm_active, ch2_pwm_active, sfr_addr, sfr_wdata} = '0;
    counter_value = 16'h0000;
    ch1_compare_value = 16'h0000;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    sfr_read(ALIGN_SEL_ADDR, rd);
    check(rd, ALIGN_SEL_RESET);
    sfr_read(CH1_MODE_ADDR, rd);
    check(rd, CH1_MODE_RESET);
    sfr_read(8'h55, rd);
    check(rd, 8'h00);
    // toggle, then frequency output on a low byte only match
    r = rnd();
    c = r[15:0];
    ch1_compare_value <= c;
    exp_o = 1'b0;
    sfr_write(CH1_MODE_ADDR, 8'h44);
    for (int k = 0; k < 3; k++) begin
      exp_o = ~exp_o;
      step(c, ~c, exp_o);
    end
    step({~c[15:8], c[7:0]}, ~c, exp_o);
    sfr_write(CH1_MODE_ADDR, 8'h46);
    for (int k = 0; k < 2; k++) begin
      exp_o = ~exp_o;
      step({~c[15:8], c[7:0]}, ~c, exp_o);
    end
    // edge aligned pwm, 16-bit then narrow
    r = rnd();
    c = r[15:0] | 16'h0101;
    ch1_compare_value <= c;
    sfr_write(CH1_MODE_ADDR, 8'hc2);
    step(c - 16'h0001, c - 16'h0001, 1'b1);
    step(c, c, 1'b0);
    sfr_write(CH1_MODE_ADDR, 8'h42);
    step({8'hff, c[15:8] - 8'h01}, {8'hff, c[15:8] - 8'h01}, 1'b1);
    step({8'h00, c[15:8]}, {8'h00, c[15:8]}, 1'b0);
    // center aligned 16-bit pwm: top of count folds to zero, quarter count folds to half scale
    sfr_write(ALIGN_SEL_ADDR, 8'h02);
    ch1_compare_value <= 16'h8000;
    sfr_write(CH1_MODE_ADDR, 8'hc2);
    step(16'hffff, 16'hffff, 1'b1);
    step(16'h4000, 16'h4000, 1'b0);
    // alignment select against pwm and non-pwm channels; unmapped writes dropped
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      d = {5'h00, i[2:0]};
      m = (r[8] ? 8'h02 : (r[11] ? 8'h06 : 8'h04)) | {1'b0, r[12], 6'h00};
      sfr_write(8'h55, 8'hff);
      sfr_write_read(ALIGN_SEL_ADDR, d, rd);
      check(rd, d);
      sfr_write(CH1_MODE_ADDR, m);
      @(posedge clk_sys);
      ch0_pwm_active <= r[9];
      ch2_pwm_active <= r[10];
      @(posedge clk_sys);
      #1;
      check(center_align_active, exp_center(d, m, r[9], r[10]));
      sfr_read(ALIGN_SEL_ADDR, rd);
      check(rd, d & 8'h07);
    end
    // match flag needs the comparator
    r = rnd();
    c = r[15:0];
    ch1_compare_value <= c;
    for (int i = 0; i < 4; i++) begin
      m = i[1] ? 8'h49 : 8'h09;
      sfr_write(CH1_MODE_ADDR, m);
      sfr_read(CH1_MODE_ADDR, rd);
      check(rd, m);
      @(posedge clk_sys);
      counter_value <= i[0] ? c : ~c;
      #1;
      check(ch1_flag_set, i[0] & i[1]);
    end
    // capture on each edge enable combination, with interrupt masking
    // the pin has not moved yet, so the capture register still holds its reset value
    cap = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      m = {2'b00, i[1:0], 3'b000, i[2]};
      sfr_write(CH1_MODE_ADDR, m);
      flag_clear <= 1'b1;
      @(posedge clk_sys);
      flag_clear <= 1'b0;
      flg = 1'b0;
      for (int e = 0; e < 2; e++) begin
        r = rnd();
        cv = r[15:0];
        @(posedge clk_sys);
        counter_value <= cv;
        edge_req <= 1'b1;
        @(posedge clk_sys);
        edge_req <= 1'b0;
        #1;
        fs = ch1_input ? i[1] : i[0];
        check(ch1_flag_set, fs);
        @(posedge clk_sys);
        #1;
        cap = fs ? cv : cap;
        flg = flg | fs;
        check(ch1_capture_value, cap);
        check(ch1_irq_request, flg & m[0]);
      end
    end
    complete_run();
  end
endmodule : pwm_align_and_ch1_mode_ctrl_bench
